// file: common/eprom_seq_pkg.sv
// Notes on behaviour
// - Main supply select chooses 5V read level or 48V programming level.
// - Positive supplies can be killed; pre-regulator set to about 15V or 71V.
// - Pre-regulator goes to its low setting whenever main supply is at 5V.
// - Substrate select chooses 5V for read or 60V for programming.
// - Drain pull-down and negative-nine enable are never both on.
// - Gate switch and negative-nine enable are never both on.
// - Data write drivers are enabled before read data is sampled.
// - Read data sampled more than 20 us after a new address.
// - Supply checks use only the upper 8 bits of each 10-bit result.
// - A supply meant to be off reads 00 through 01.
// - Main supply at 5V reads 0E through 11.
// - Main supply at 48V reads 8E through 9C.
// - Substrate at 60V reads AF through C3.
// - Program pulse starts 130 us after supplies pulse low, lasts 2.5 ms.
// - Data stable 500 us before pulse, held 10 ms after it.
// - Drain and gate supplies return high 50 us after pulse ends.
// - Inverted address driven 500 us before supplies pulse low.
// - Inverted address held 30 us after supplies fall, then true address.
// - True address driven 100 us before program pulse.
// - True address held 10 ms after program pulse ends.
// - Supplies low 2.65 ms and high 11 ms per cycle; the code holds them low 2.68 ms.
package eprom_seq_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int READ_WAIT_NS = 20000;
  localparam int READ_WAIT_CYC = READ_WAIT_NS * CLK_MHZ / 1000 + 1;
  localparam int ADDR_INV_SETUP_US = 500;
  localparam int ADDR_INV_HOLD_US = 30;
  localparam int VSETUP_US = 130;
  localparam int PULSE_US = 2500;
  localparam int VHOLD_US = 50;
  localparam int VLOW_US = 2650;
  localparam int VHIGH_US = 11000;
  localparam int ADDR_HOLD_US = 10000;
  localparam int SUPPLY_SETTLE_US = 1000;
  localparam int US_CYC = CLK_MHZ;
  localparam int TMR_W = 24;

  // ------------------------------------------------------------
  // Acceptance windows (upper 8 ADC bits)
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_MIN = 8'h00;
  localparam logic [7:0] OFF_MAX = 8'h01;
  localparam logic [7:0] LOW5_MIN = 8'h0E;
  localparam logic [7:0] LOW5_MAX = 8'h11;
  localparam logic [7:0] PRE_LO_MIN = 8'h28;
  localparam logic [7:0] PRE_LO_MAX = 8'h38;
  localparam logic [7:0] MAIN_HI_MIN = 8'h8E;
  localparam logic [7:0] MAIN_HI_MAX = 8'h9C;
  localparam logic [7:0] SUB_HI_MIN = 8'hAF;
  localparam logic [7:0] SUB_HI_MAX = 8'hC3;
  localparam logic [7:0] PRE_HI_MIN = 8'hD0;
  localparam logic [7:0] PRE_HI_MAX = 8'hF0;

  // ------------------------------------------------------------
  // APB register map
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] ADDR_OFF = 8'h04;
  localparam logic [7:0] WDATA_OFF = 8'h08;
  localparam logic [7:0] STATUS_OFF = 8'h0C;
  localparam logic [7:0] RDATA_OFF = 8'h10;
  localparam logic [7:0] ADC_OFF = 8'h14;
  localparam int CTRL_READ_BIT = 0;
  localparam int CTRL_PROG_BIT = 1;
  localparam int CTRL_PWR_BIT = 2;
  localparam int CTRL_ERRCLR_BIT = 3;

  typedef enum logic [3:0] {
    ST_OFF    = 4'h8,
    ST_READY  = 4'h1,
    ST_RADDR  = 4'h3,
    ST_HV_UP  = 4'h2,
    ST_ACW    = 4'h6,
    ST_ACH    = 4'h7,
    ST_ATW    = 4'h5,
    ST_PULSE  = 4'h4,
    ST_VHOLD  = 4'hC,
    ST_VHIGH  = 4'hD,
    ST_LV_DN  = 4'h9,
    ST_FAULT  = 4'h0
  } seq_state_t;

  typedef struct packed {
    logic main_level_select;
    logic positive_supply_kill;
    logic preregulator_level_select;
    logic substrate_level_select;
    logic drain_pulldown_switch;
    logic gate_regulator_switch;
    logic neg_nine_enable;
  } supply_ctrl_t;

  typedef struct packed {
    logic [9:0] pre;
    logic [9:0] main;
    logic [9:0] sub;
  } adc_in_t;

endpackage

// file: hw/eprom_program_sequencer.sv
`timescale 1ns/1ps
module eprom_program_sequencer
  import eprom_seq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire adc_in_t adc,
  input wire logic [7:0] data_in,
  output supply_ctrl_t supply,
  output logic [7:0] addr_out,
  output logic [7:0] data_out,
  output logic data_drive_en,
  output logic prog_pulse
);

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  logic wr_acc;
  logic rd_acc;
  logic mapped;
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  assign mapped = (paddr == CTRL_OFF) || (paddr == ADDR_OFF) || (paddr == WDATA_OFF) ||
                  (paddr == STATUS_OFF) || (paddr == RDATA_OFF) || (paddr == ADC_OFF);

  logic [7:0] addr_reg;
  logic [7:0] wdata_reg;
  logic [7:0] rdata_reg;
  logic err_reg;
  logic done_reg;
  logic go_read;
  logic go_prog;
  logic pwr_req;
  seq_state_t state_reg;
  logic [TMR_W-1:0] tmr_reg;
  logic [TMR_W-1:0] hold_reg;

  assign go_read = wr_acc && paddr == CTRL_OFF && pwdata[CTRL_READ_BIT];
  assign go_prog = wr_acc && paddr == CTRL_OFF && pwdata[CTRL_PROG_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      pwr_req <= 1'b0;
    end else if (wr_acc) begin
      if (paddr == ADDR_OFF) begin
        addr_reg <= pwdata[7:0];
      end else if (paddr == WDATA_OFF) begin
        wdata_reg <= pwdata[7:0];
      end else if (paddr == CTRL_OFF) begin
        pwr_req <= pwdata[CTRL_PWR_BIT];
      end
    end
  end

  // ------------------------------------------------------------
  // Supply monitor
  // ------------------------------------------------------------
  logic [7:0] pre8;
  logic [7:0] main8;
  logic [7:0] sub8;
  assign pre8 = adc.pre[9:2];
  assign main8 = adc.main[9:2];
  assign sub8 = adc.sub[9:2];

  function automatic logic inwin(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
    inwin = (v >= lo) && (v <= hi);
  endfunction

  logic supplies_ok;
  logic check_en;
  always_comb begin
    if (supply.positive_supply_kill) begin
      supplies_ok = inwin(pre8, OFF_MIN, OFF_MAX) && inwin(main8, OFF_MIN, OFF_MAX) &&
                    inwin(sub8, OFF_MIN, OFF_MAX);
    end else if (supply.main_level_select) begin
      supplies_ok = inwin(pre8, PRE_HI_MIN, PRE_HI_MAX) &&
                    inwin(main8, MAIN_HI_MIN, MAIN_HI_MAX) &&
                    inwin(sub8, SUB_HI_MIN, SUB_HI_MAX);
    end else begin
      supplies_ok = inwin(pre8, PRE_LO_MIN, PRE_LO_MAX) &&
                    inwin(main8, LOW5_MIN, LOW5_MAX) &&
                    inwin(sub8, LOW5_MIN, LOW5_MAX);
    end
  end
  // Checks only once supplies had time to settle after a level change
  assign check_en = (state_reg == ST_READY) || (state_reg == ST_RADDR) || (state_reg == ST_ACW) ||
                    (state_reg == ST_ACH) || (state_reg == ST_ATW) || (state_reg == ST_PULSE) ||
                    (state_reg == ST_VHOLD) || (state_reg == ST_VHIGH);

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  localparam logic [TMR_W-1:0] T_READ = TMR_W'(READ_WAIT_CYC);
  localparam logic [TMR_W-1:0] T_SETTLE = TMR_W'(SUPPLY_SETTLE_US * US_CYC);
  // A state lasts its load plus one cycle, so program phases load one less
  localparam logic [TMR_W-1:0] T_ACW = TMR_W'(ADDR_INV_SETUP_US * US_CYC - 1);
  localparam logic [TMR_W-1:0] T_ACH = TMR_W'(ADDR_INV_HOLD_US * US_CYC - 1);
  localparam logic [TMR_W-1:0] T_ATW = TMR_W'((VSETUP_US - ADDR_INV_HOLD_US) * US_CYC - 1);
  localparam logic [TMR_W-1:0] T_PULSE = TMR_W'(PULSE_US * US_CYC - 1);
  localparam logic [TMR_W-1:0] T_VHOLD = TMR_W'(VHOLD_US * US_CYC - 1);
  localparam logic [TMR_W-1:0] T_VHIGH = TMR_W'(VHIGH_US * US_CYC - 1);
  localparam logic [TMR_W-1:0] T_AHOLD = TMR_W'(ADDR_HOLD_US * US_CYC);

  logic tmr_done;
  assign tmr_done = (tmr_reg == '0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_OFF;
      tmr_reg <= '0;
    end else if (check_en && !supplies_ok) begin
      state_reg <= ST_FAULT;
      tmr_reg <= '0;
    end else begin
      if (!tmr_done) begin
        tmr_reg <= tmr_reg - 1'b1;
      end
      case (state_reg)
        ST_OFF: begin
          if (pwr_req) begin
            state_reg <= ST_LV_DN;
            tmr_reg <= T_SETTLE;
          end
        end
        ST_LV_DN: begin
          if (tmr_done) begin
            state_reg <= ST_READY;
          end
        end
        ST_READY: begin
          if (!pwr_req) begin
            state_reg <= ST_OFF;
          end else if (go_read) begin
            state_reg <= ST_RADDR;
            tmr_reg <= T_READ;
          end else if (go_prog) begin
            state_reg <= ST_HV_UP;
            tmr_reg <= T_SETTLE;
          end
        end
        ST_RADDR: begin
          if (tmr_done) begin
            state_reg <= ST_READY;
          end
        end
        ST_HV_UP: begin
          if (tmr_done) begin
            state_reg <= ST_ACW;
            tmr_reg <= T_ACW;
          end
        end
        ST_ACW: begin
          if (tmr_done) begin
            state_reg <= ST_ACH;
            tmr_reg <= T_ACH;
          end
        end
        ST_ACH: begin
          if (tmr_done) begin
            state_reg <= ST_ATW;
            tmr_reg <= T_ATW;
          end
        end
        ST_ATW: begin
          if (tmr_done) begin
            state_reg <= ST_PULSE;
            tmr_reg <= T_PULSE;
          end
        end
        ST_PULSE: begin
          if (tmr_done) begin
            state_reg <= ST_VHOLD;
            tmr_reg <= T_VHOLD;
          end
        end
        ST_VHOLD: begin
          if (tmr_done) begin
            state_reg <= ST_VHIGH;
            tmr_reg <= T_VHIGH;
          end
        end
        ST_VHIGH: begin
          if (tmr_done) begin
            state_reg <= ST_LV_DN;
            tmr_reg <= T_SETTLE;
          end
        end
        ST_FAULT: begin
          if (wr_acc && paddr == CTRL_OFF && pwdata[CTRL_ERRCLR_BIT]) begin
            state_reg <= ST_OFF;
          end
        end
        default: begin
          state_reg <= ST_OFF;
        end
      endcase
    end
  end

  // Address/data hold after pulse, counted across the high phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_reg <= '0;
    end else if (state_reg == ST_PULSE && tmr_done) begin
      hold_reg <= T_AHOLD;
    end else if (hold_reg != '0) begin
      hold_reg <= hold_reg - 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  logic hv_state;
  logic vlow_state;
  assign hv_state = (state_reg == ST_HV_UP) || (state_reg == ST_ACW) || (state_reg == ST_ACH) ||
                    (state_reg == ST_ATW) || (state_reg == ST_PULSE) || (state_reg == ST_VHOLD) ||
                    (state_reg == ST_VHIGH);
  assign vlow_state = (state_reg == ST_ACH) || (state_reg == ST_ATW) || (state_reg == ST_PULSE) ||
                      (state_reg == ST_VHOLD);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply <= '{default: 1'b0, positive_supply_kill: 1'b1};
    end else begin
      supply.positive_supply_kill <= (state_reg == ST_OFF) || (state_reg == ST_FAULT);
      supply.main_level_select <= hv_state;
      supply.preregulator_level_select <= hv_state;
      supply.substrate_level_select <= hv_state;
      // Read: both drain and gate at -9V; program: switches pulse them
      supply.neg_nine_enable <= !hv_state && state_reg != ST_OFF && state_reg != ST_FAULT;
      supply.drain_pulldown_switch <= vlow_state;
      supply.gate_regulator_switch <= vlow_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_pulse <= 1'b0;
      addr_out <= 8'h00;
      data_out <= 8'h00;
      data_drive_en <= 1'b0;
    end else begin
      prog_pulse <= (state_reg == ST_PULSE);
      if (state_reg == ST_ACW || state_reg == ST_ACH) begin
        addr_out <= ~addr_reg;
      end else if (hv_state || hold_reg != '0 || state_reg == ST_RADDR) begin
        addr_out <= addr_reg;
      end
      if (state_reg == ST_RADDR) begin
        data_out <= 8'h00;
      end else if (state_reg == ST_ACW || hold_reg != '0) begin
        data_out <= wdata_reg;
      end
      // Drivers on for reads and around the whole program cycle
      data_drive_en <= (state_reg == ST_RADDR) || (state_reg == ST_READY) || hv_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= 8'h00;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      if (state_reg == ST_RADDR && tmr_done && data_drive_en) begin
        rdata_reg <= data_in;
      end
      if ((state_reg == ST_RADDR || state_reg == ST_VHIGH) && tmr_done) begin
        done_reg <= 1'b1;
      end else if (go_read || go_prog) begin
        done_reg <= 1'b0;
      end
      if (check_en && !supplies_ok) begin
        err_reg <= 1'b1;
      end else if (wr_acc && paddr == CTRL_OFF && pwdata[CTRL_ERRCLR_BIT]) begin
        err_reg <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // APB read path, no wait states
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel && !penable) begin
        if (paddr == CTRL_OFF) begin
          prdata <= {29'h0, pwr_req, 2'b00};
        end else if (paddr == ADDR_OFF) begin
          prdata <= {24'h0, addr_reg};
        end else if (paddr == WDATA_OFF) begin
          prdata <= {24'h0, wdata_reg};
        end else if (paddr == STATUS_OFF) begin
          prdata <= {22'h0, supplies_ok, prog_pulse, state_reg, 1'b0, done_reg, err_reg,
                     state_reg != ST_READY && state_reg != ST_OFF && state_reg != ST_FAULT};
        end else if (paddr == RDATA_OFF) begin
          prdata <= {24'h0, rdata_reg};
        end else if (paddr == ADC_OFF) begin
          prdata <= {8'h00, pre8, main8, sub8};
        end else begin
          prdata <= 32'h0000_0000;
        end
      end
    end
  end

endmodule

// file: sim/eprom_seq_checker.sv
`timescale 1ns/1ps
module eprom_seq_checker
  import eprom_seq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire supply_ctrl_t supply,
  input wire logic [7:0] addr_out,
  input wire logic [7:0] data_out,
  input wire logic prog_pulse
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [23:0] dcnt;
  logic [23:0] pcnt;
  logic [23:0] fcnt;
  logic dsw;
  assign dsw = supply.drain_pulldown_switch;
  // --------------------
  // Phase counters
  // --------------------
  // One cycle of slack: the edge that starts a count is seen one sample late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dcnt <= '0;
      pcnt <= '0;
      fcnt <= '0;
    end else begin
      dcnt <= dsw ? dcnt + 24'h1 : 24'h0;
      pcnt <= prog_pulse ? pcnt + 24'h1 : 24'h0;
      fcnt <= prog_pulse ? 24'h0 : fcnt + 24'h1;
    end
  end
  a_drain_excl: assert property (!(dsw && supply.neg_nine_enable))
    else $error("drain pull-down and negative supply both on");
  a_gate_excl: assert property (!(supply.gate_regulator_switch && supply.neg_nine_enable))
    else $error("gate switch and negative supply both on");
  a_prereg_read: assert property (!supply.main_level_select |-> !supply.preregulator_level_select)
    else $error("pre-regulator high while main supply low");
  a_pulse_setup: assert property ($rose(prog_pulse) |-> dcnt inside {[12999:13001]})
    else $error("pulse start not 130 us after supplies low");
  a_pulse_width: assert property ($fell(prog_pulse) |-> pcnt inside {[249999:250001]})
    else $error("program pulse width wrong");
  a_supply_hold: assert property ($fell(dsw) && !supply.positive_supply_kill |-> fcnt inside {[4999:5001]})
    else $error("supplies not back 50 us after pulse");
  a_addr_true: assert property (dsw && $changed(addr_out) |-> dcnt inside {[2999:3001]})
    else $error("address flip not 30 us after supplies low");
  a_pulse_stable: assert property (prog_pulse |=> $stable(data_out) && $stable(addr_out))
    else $error("data or address moved around the pulse");
endmodule
bind eprom_program_sequencer eprom_seq_checker i_eprom_seq_checker (
  .pclk(pclk), .presetn(presetn), .supply(supply), .addr_out(addr_out),
  .data_out(data_out), .prog_pulse(prog_pulse));

// file: sim/eprom_socket_model.sv
`timescale 1ns/1ps
module eprom_socket_model
  import eprom_seq_pkg::*;
(
  input wire logic pclk,
  input wire supply_ctrl_t supply,
  input wire logic [7:0] addr_out,
  input wire logic [7:0] data_out,
  input wire logic data_drive_en,
  input wire logic prog_pulse,
  input wire logic bad,
  output adc_in_t adc,
  output logic [7:0] data_in
);
  logic [7:0] mem [256];
  logic [7:0] pre8;
  logic [7:0] main8;
  logic [7:0] sub8;
  initial data_in = 8'h00;
  initial foreach (mem[i]) mem[i] = 8'h00;
  // Blank cells read 00; drivers off leave the sense line toggling
  always @(posedge pclk) begin
    if (prog_pulse) mem[addr_out] <= data_out;
    data_in <= data_drive_en ? mem[addr_out] : ~data_in;
  end
  assign pre8 = supply.preregulator_level_select ? 8'hE0 : 8'h30;
  assign main8 = bad ? 8'h20 : (supply.main_level_select ? 8'h95 : 8'h10);
  assign sub8 = supply.substrate_level_select ? 8'hB8 : 8'h10;
  // Low bits set on purpose: the sequencer must ignore them
  assign adc = supply.positive_supply_kill ? '0 : {pre8, 2'h3, main8, 2'h3, sub8, 2'h3};
endmodule

// file: sim/eprom_program_sequencer_bench.sv
`timescale 1ns/1ps
module eprom_program_sequencer_bench
  import eprom_seq_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, bad = 0, hv_seen = 0, err;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, q;
  logic [31:0] prdata;
  logic pready, pslverr, data_drive_en, prog_pulse;
  adc_in_t adc;
  supply_ctrl_t supply;
  logic [7:0] data_in, addr_out, data_out;
  int failures = 0, total_checks = 0, cycles = 0;
  realtime t0;
  eprom_program_sequencer i_eprom_program_sequencer (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .adc(adc), .data_in(data_in), .supply(supply),
    .addr_out(addr_out), .data_out(data_out), .data_drive_en(data_drive_en), .prog_pulse(prog_pulse));
  eprom_socket_model i_eprom_socket_model (.pclk(pclk), .supply(supply), .addr_out(addr_out),
    .data_out(data_out), .data_drive_en(data_drive_en), .prog_pulse(prog_pulse), .bad(bad),
    .adc(adc), .data_in(data_in));
  initial forever #5 pclk = ~pclk;
  // Whole program cycle is about 1.6M cycles; no shorter count exists
  always @(posedge pclk) begin
    cycles++;
    if (prog_pulse && supply.main_level_select && supply.substrate_level_select) hv_seen = 1;
    if (cycles == 3000000) begin
      failures++;
      test_done();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t mismatch got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wait_idle();
    int i;
    i = 0;
    do begin
      apb(0, STATUS_OFF, 0);
      i++;
    end while (q[0] !== 1'b0 && i < 700000);
  endtask
  task t_reset_unmapped();
    chk(supply, 7'h20);
    apb(0, 8'h20, 0);
    chk(err, 1'b1);
  endtask
  task t_power_up();
    apb(1, CTRL_OFF, 32'h4);
    wait_idle();
    chk(q[1], 1'b0);
    chk({supply.main_level_select, supply.positive_supply_kill}, 2'h0);
    chk({supply.preregulator_level_select, supply.neg_nine_enable}, 2'h1);
    apb(0, ADC_OFF, 0);
    chk(q[23:0], 24'h301010);
  endtask
  task t_program();
    apb(1, ADDR_OFF, 32'h5);
    apb(1, WDATA_OFF, 32'hA5);
    apb(1, CTRL_OFF, 32'h6);
    wait_idle();
    chk(q[2:1], 2'h2);
    chk(hv_seen, 1'b1);
  endtask
  task t_read(input logic [7:0] a, input logic [7:0] exp);
    apb(1, ADDR_OFF, {24'h0, a});
    t0 = $realtime;
    apb(1, CTRL_OFF, 32'h5);
    wait_idle();
    chk($realtime - t0 > 20000.0, 1'b1);
    apb(0, RDATA_OFF, 0);
    chk(q[7:0], exp);
  endtask
  task t_fault();
    int i;
    bad <= 1;
    i = 0;
    do begin
      apb(0, STATUS_OFF, 0);
      i++;
    end while (q[1] !== 1'b1 && i < 1000);
    chk(q[1], 1'b1);
    chk(supply.positive_supply_kill, 1'b1);
    bad <= 0;
    apb(1, CTRL_OFF, 32'h8);
    apb(0, STATUS_OFF, 0);
    chk(q[1], 1'b0);
  endtask
  task test_done();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    t_reset_unmapped();
    t_power_up();
    t_program();
    t_read(8'h05, 8'hA5);
    t_read(8'h06, 8'h00);
    t_fault();
    test_done();
  end
endmodule
